// *** verilog/fprc_defs.vh ***
// constants for the flash power and reset control block
`ifndef FPRC_DEFS_VH
`define FPRC_DEFS_VH
`define FPRC_CLK_MHZ        25
`define FPRC_PULSE_RD_US    5
`define FPRC_PULSE_PE_US    25
`define FPRC_RECOV_NS       200
`define FPRC_PULSE_RD_CYC   (`FPRC_PULSE_RD_US * `FPRC_CLK_MHZ)
`define FPRC_PULSE_PE_CYC   (`FPRC_PULSE_PE_US * `FPRC_CLK_MHZ)
`define FPRC_RECOV_CYC      ((`FPRC_RECOV_NS * `FPRC_CLK_MHZ + 999) / 1000)
`define FPRC_SLEEP_CYC      16
`define FPRC_PIN_IDLE       21'h1e0000
`define FPRC_WC_MIN         3
`define FPRC_WC_MAX         34
`define FPRC_CMD_RESET      8'hf0
`define FPRC_CMD_SECSI      8'h88
`define FPRC_CMD_CFGREG     8'hd0
`define FPRC_CMD_LOCK       8'h40
`define FPRC_CMD_ID         8'h90
`define FPRC_CMD_CFI        8'h98
`define FPRC_CMD_BUFLOAD    8'h25
`define FPRC_MODE_ARRAY     3'h0
`define FPRC_MODE_LOCK      3'h1
`define FPRC_MODE_SECSI     3'h2
`define FPRC_MODE_CFG       3'h3
`define FPRC_MODE_IDCFI     3'h4
`endif

// *** verilog/fprc_top.v ***
// power saving, output gating and reset sequencing for a muxed flash bus
`timescale 1ns/1ps
`include "fprc_defs.vh"
module fprc_top (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // flash pins (asynchronous, active low where named _n)
   input  wire        reset_pin_n,
   input  wire        chip_sel_n,
   input  wire        write_n,
   input  wire        out_gate_n,
   input  wire        flash_clk,
   input  wire [15:0] muxed_addr_data_bus_in,
   output reg  [15:0] muxed_addr_data_bus_out,
   output reg         muxed_addr_data_bus_oe,
   output reg         wait_out,
   // core side
   input  wire        core_busy,
   input  wire        sync_mode,
   input  wire [15:0] core_rdata,
   input  wire        core_ready,
   // status
   output reg         standby_q,
   output reg         sleep_q,
   output reg         in_reset_q,
   output reg         read_ready_q,
   output reg  [2:0]  region_q,
   output reg         pulse_short_q,
   output reg         buf_err_q
);
   localparam ST_READ  = 2'h0;
   localparam ST_RESET = 2'h1;
   localparam ST_RECOV = 2'h2;
   localparam [11:0] PULSE_RD = `FPRC_PULSE_RD_CYC;
   localparam [11:0] PULSE_PE = `FPRC_PULSE_PE_CYC;
   localparam [11:0] RECOV    = `FPRC_RECOV_CYC;
   localparam [11:0] SLEEP_N  = `FPRC_SLEEP_CYC;

   // latency budget, counted from a pin edge to the status flop that reports it:
   //    two synchroniser flops, then one registered decision, so about three
   //    clocks; every window in the checker allows for that margin.
   // the pulse and recovery counts are whole clocks of this block's clock, so
   //    a pulse is measured to within one period; the recovery count is
   //    rounded up so reads are never released early.
   // the sleep idle count is a local choice: long enough to skip bus jitter,
   //    short enough that a parked bus quickly drops to low power.
   // the core side (busy, burst mode, read data) is on this clock already and
   //    is used as it arrives; only the pins are synchronised.
   // limitation: a pin pulse shorter than one clock may be missed entirely,
   //    which is harmless for reset since such a pulse is far below minimum.
   // trade-off: the status outputs are all registered, costing one clock of
   //    latency but keeping every top-level output glitch free.

   // one-step increment shared by the reset, recovery and idle counters
   function [11:0] step12;
      input [11:0] v;
      begin
         step12 = v + 12'h001;
      end
   endfunction

   // total bus cycles of a buffer load: header, word count, then count+1 words
   function [6:0] load_len;
      input [5:0] wc;
      begin
         load_len = {1'b0, wc} + 7'h03;
      end
   endfunction

   // two-flop synchronisers for every pin
   // reset loads the idle pin levels so no false edge or change is seen
   // when the block comes out of reset
   reg  [20:0] s1_q;
   reg  [20:0] s2_q;
   wire [20:0] pins = {reset_pin_n, chip_sel_n, write_n, out_gate_n, flash_clk,
                       muxed_addr_data_bus_in};
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         s1_q <= `FPRC_PIN_IDLE;
         s2_q <= `FPRC_PIN_IDLE;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
      end
   end
   wire        rst_n_s = s2_q[20];
   wire        cs_n_s  = s2_q[19];
   wire        we_n_s  = s2_q[18];
   wire        oe_n_s  = s2_q[17];
   wire        fclk_s  = s2_q[16];
   wire [15:0] bus_s   = s2_q[15:0];

   // previous samples for edge and change detection
   reg        we_prev_q;
   reg        fclk_prev_q;
   reg [15:0] addr_prev_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         we_prev_q   <= 1'b1;
         fclk_prev_q <= 1'b0;
         addr_prev_q <= 16'h0000;
      end else begin
         we_prev_q   <= we_n_s;
         fclk_prev_q <= fclk_s;
         addr_prev_q <= bus_s;
      end
   end
   // standby is a pure level decode; an embedded operation keeps the device
   // awake even with the chip deselected
   wire in_standby = rst_n_s && cs_n_s && !core_busy;
   wire write_strb = we_prev_q && !we_n_s && !in_standby;
   // any move of the address restarts the idle count; the gate pins play no
   // part, since sleep must not hinge on the control strobes
   wire addr_chg   = (bus_s != addr_prev_q);
   wire fclk_chg   = fclk_s != fclk_prev_q;

   // reset pulse measurement and recovery sequencer
   //    read:  idle, waiting for the reset pin to drop
   //    reset: pin low, the pulse length is counted in clocks
   //    recov: pin released after an interrupted embedded operation; reads
   //           stay blocked until the recovery count has run out
   // whether the pulse met its minimum depends on what was running when it
   // started, so the busy level is captured on entry, not on release.
   // a short pulse still resets the block; it is only reported, because a
   // host that ignores the minimum gets no guarantee either way.
   // the system reset wired to the pin reaches this same path.
   reg [1:0]  st_q;
   reg [11:0] cnt_q;
   reg        busy_at_rst_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q          <= ST_READ;
         cnt_q         <= 12'h000;
         busy_at_rst_q <= 1'b0;
         in_reset_q    <= 1'b0;
         read_ready_q  <= 1'b1;
         pulse_short_q <= 1'b0;
      end else begin
         case (st_q)
            ST_READ: begin
               if (!rst_n_s) begin
                  st_q          <= ST_RESET;
                  cnt_q         <= 12'h001;
                  busy_at_rst_q <= core_busy;
                  in_reset_q    <= 1'b1;
                  read_ready_q  <= 1'b0;
               end
            end
            ST_RESET: begin
               if (rst_n_s) begin
                  // a pulse shorter than the minimum is flagged, but still honoured
                  pulse_short_q <= (cnt_q < (busy_at_rst_q ? PULSE_PE : PULSE_RD));
                  in_reset_q    <= 1'b0;
                  cnt_q         <= 12'h000;
                  if (busy_at_rst_q)
                     st_q <= ST_RECOV;
                  else begin
                     st_q         <= ST_READ;
                     read_ready_q <= 1'b1;
                  end
               end else if (cnt_q != 12'hfff)
                  cnt_q <= step12(cnt_q);
            end
            ST_RECOV: begin
               // reads become valid within the recovery window; the count is the
               // number of clocks since the pin went back high
               if (step12(cnt_q) >= RECOV) begin
                  st_q         <= ST_READ;
                  read_ready_q <= 1'b1;
               end else
                  cnt_q <= step12(cnt_q);
               // a fresh pulse during recovery restarts the measurement
               if (!rst_n_s) begin
                  st_q       <= ST_RESET;
                  cnt_q      <= 12'h001;
                  in_reset_q <= 1'b1;
               end
            end
            default: st_q <= ST_READ;
         endcase
      end
   end

   // command tracking: region entry, software reset exit, buffer load count
   // only the low byte of the bus is decoded; the address half is ignored
   // here because the region codes are unique by data alone.
   // the load counters are one bit wider than any legal load so that an
   // oversize word count is flagged as soon as it arrives and still counted out
   // to its end, rather than wrapping and swallowing the commands that follow.
   reg [1:0] wcyc_q;
   reg [6:0] bcnt_q;
   reg [6:0] blen_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         region_q  <= `FPRC_MODE_ARRAY;
         wcyc_q    <= 2'h0;
         bcnt_q    <= 7'h00;
         blen_q    <= 7'h00;
         buf_err_q <= 1'b0;
      end else if (in_reset_q) begin
         region_q <= `FPRC_MODE_ARRAY;
         bcnt_q   <= 7'h00;
      end else if (write_strb && read_ready_q) begin
         if (bcnt_q != 7'h00) begin
            // word count plus one data words follow the header; inside a load
            // every strobe is a data cycle, so data equal to a command is harmless
            if (wcyc_q == 2'h1) begin
               blen_q    <= load_len(bus_s[5:0]);
               buf_err_q <= (load_len(bus_s[5:0]) > `FPRC_WC_MAX);
               wcyc_q    <= 2'h2;
            end
            if (bcnt_q + 7'h01 >= blen_q && wcyc_q == 2'h2)
               bcnt_q <= 7'h00;
            else
               bcnt_q <= bcnt_q + 7'h01;
         end else if (bus_s[7:0] == `FPRC_CMD_RESET) begin
            // software reset: back to the array from any region, and a no-op
            // when the array is already selected
            region_q <= `FPRC_MODE_ARRAY;
         end else if (bus_s[7:0] == `FPRC_CMD_BUFLOAD &&
                      region_q == `FPRC_MODE_SECSI) begin
            // header cycle of a secured-region load; the count follows next
            bcnt_q <= 7'h01;
            wcyc_q <= 2'h1;
         end else if (region_q == `FPRC_MODE_ARRAY) begin
            case (bus_s[7:0])
               `FPRC_CMD_LOCK:   region_q <= `FPRC_MODE_LOCK;
               `FPRC_CMD_SECSI:  region_q <= `FPRC_MODE_SECSI;
               `FPRC_CMD_CFGREG: region_q <= `FPRC_MODE_CFG;
               `FPRC_CMD_ID:     region_q <= `FPRC_MODE_IDCFI;
               `FPRC_CMD_CFI:    region_q <= `FPRC_MODE_IDCFI;
               default:          region_q <= region_q;
            endcase
         end
      end
   end

   // automatic sleep: stable address and clock, no reset in progress; other pins ignored
   // chip select, write strobe and output gate never touch this counter, so
   // sleep is entered and kept whatever the host does with them.
   // burst mode holds the counter at zero: a burst relies on the device clock
   // and must never find the array asleep.
   reg [11:0] idle_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         idle_q  <= 12'h000;
         sleep_q <= 1'b0;
      end else if (addr_chg || fclk_chg || sync_mode || in_reset_q) begin
         idle_q  <= 12'h000;
         sleep_q <= 1'b0;
      end else if (step12(idle_q) >= SLEEP_N) begin
         sleep_q <= 1'b1;
      end else
         idle_q <= step12(idle_q);
   end

   // output stage: data held in sleep, tri-state by standby or output gate
   // the enable is the only thing the gate and standby act on; the data word
   // itself is kept so that waking or re-enabling shows the same value.
   // wait is left out of the gating on purpose: the host polls it always.
   reg [15:0] data_hold_q;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         data_hold_q             <= 16'h0000;
         muxed_addr_data_bus_out <= 16'h0000;
         muxed_addr_data_bus_oe  <= 1'b0;
         wait_out                <= 1'b0;
         standby_q               <= 1'b0;
      end else begin
         standby_q <= in_standby;
         // sleep freezes the latch so the bus keeps the last word
         if (core_ready && !sleep_q)
            data_hold_q <= core_rdata;
         // the pins follow the latch only while awake, so the word on the bus
         // cannot slip in the cycle that sleep is entered
         if (!sleep_q)
            muxed_addr_data_bus_out <= data_hold_q;
         muxed_addr_data_bus_oe  <= !oe_n_s && !in_standby && !in_reset_q
                                    && read_ready_q;
         // wait is driven whatever the output gate does
         wait_out <= !core_ready || !read_ready_q;
      end
   end
endmodule

// *** tb/fprc_monitor.sv ***
// assertion checker bound to the flash power and reset control top
`timescale 1ns/1ps
module fprc_monitor (
   // clock, reset, pins and core side inputs
   input wire        clk, reset, reset_pin_n, chip_sel_n, out_gate_n, core_busy, sync_mode,
   input wire [15:0] muxed_addr_data_bus_in, muxed_addr_data_bus_out,
   // outputs watched
   input wire        muxed_addr_data_bus_oe, standby_q, sleep_q, in_reset_q, read_ready_q,
   input wire [2:0]  region_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // windows allow for the two sync flops and the output flop
   a_standby_entry: assert property ((chip_sel_n && reset_pin_n && !core_busy) [*6] |-> standby_q)
      else $error("standby not entered");
   a_busy_no_stby: assert property (core_busy [*6] |-> !standby_q) else $error("standby while busy");
   a_standby_hiz: assert property (standby_q |-> !muxed_addr_data_bus_oe) else $error("bus driven");
   a_gate_release: assert property (out_gate_n [*6] |-> !muxed_addr_data_bus_oe)
      else $error("bus not released");
   // a moved address restarts the idle count, so no sleep for a while
   a_sleep_restart: assert property ($changed(muxed_addr_data_bus_in) |-> ##4 !sleep_q [*8])
      else $error("sleep too early");
   a_sleep_sync: assert property (sync_mode [*4] |-> !sleep_q) else $error("sleep in burst");
   a_sleep_hold: assert property (sleep_q && $past(sleep_q) |-> $stable(muxed_addr_data_bus_out))
      else $error("data lost in sleep");
   a_reset_array: assert property ((!reset_pin_n) [*6] |-> region_q == 3'h0)
      else $error("region kept in reset");
   a_recover_time: assert property ($fell(in_reset_q) |-> ##[0:7] read_ready_q)
      else $error("slow recovery");
endmodule
bind fprc_top fprc_monitor u_mon (.clk(clk), .reset(reset), .reset_pin_n(reset_pin_n),
   .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .core_busy(core_busy),
   .sync_mode(sync_mode), .muxed_addr_data_bus_in(muxed_addr_data_bus_in),
   .muxed_addr_data_bus_out(muxed_addr_data_bus_out),
   .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe), .standby_q(standby_q), .sleep_q(sleep_q),
   .in_reset_q(in_reset_q), .read_ready_q(read_ready_q), .region_q(region_q));

// *** tb/fprc_host.sv ***
// host controller model driving the flash control pins
`timescale 1ns/1ps
module fprc_host (
   input wire        clk,
   output reg        reset_pin_n, chip_sel_n, write_n, out_gate_n,
   output reg [15:0] bus_q
);
   initial begin
      reset_pin_n = 1'b1;
      chip_sel_n = 1'b0;
      write_n = 1'b1;
      out_gate_n = 1'b0;
      bus_q = 16'h0000;
   end
   // one command per strobe; 3 cycles low keeps it clear of the sync flops
   task cmd(input [7:0] c);
      begin
         @(posedge clk) #1 bus_q = {8'h00, c};
         write_n = 1'b0;
         repeat (3) @(posedge clk);
         #1 write_n = 1'b1;
         repeat (6) @(posedge clk);
      end
   endtask
   // system reset drives the flash reset pin for n cycles
   task pulse(input integer n);
      begin
         @(posedge clk) #1 reset_pin_n = 1'b0;
         repeat (n) @(posedge clk);
         #1 reset_pin_n = 1'b1;
         repeat (12) @(posedge clk); // no reads before recovery
      end
   endtask
endmodule

// *** tb/flash_power_reset_control_tb_top.sv ***
// self-checking bench for the flash power and reset control block
`timescale 1ns/1ps
`include "fprc_defs.vh"
module flash_power_reset_control_tb_top;
   reg         clk, reset, flash_clk, core_busy, sync_mode, core_ready, w;
   reg  [15:0] core_rdata;
   wire        rp_n, cs_n, we_n, og_n, oe, wt, sb, sl, ir, rr, ps, be;
   wire [15:0] bin, bout;
   wire [2:0]  reg_q;
   integer     err_total, num_checks, cyc, i, n;
   localparam [47:0] CMDS = {`FPRC_CMD_RESET, `FPRC_CMD_SECSI, `FPRC_CMD_CFGREG,
                             `FPRC_CMD_LOCK, `FPRC_CMD_ID, `FPRC_CMD_CFI};
   fprc_host u_host (.clk(clk), .reset_pin_n(rp_n), .chip_sel_n(cs_n), .write_n(we_n),
      .out_gate_n(og_n), .bus_q(bin));
   fprc_top u_dut (.clk(clk), .reset(reset), .reset_pin_n(rp_n), .chip_sel_n(cs_n),
      .write_n(we_n), .out_gate_n(og_n), .flash_clk(flash_clk), .muxed_addr_data_bus_in(bin),
      .muxed_addr_data_bus_out(bout), .muxed_addr_data_bus_oe(oe), .wait_out(wt),
      .core_busy(core_busy), .sync_mode(sync_mode), .core_rdata(core_rdata),
      .core_ready(core_ready), .standby_q(sb), .sleep_q(sl), .in_reset_q(ir),
      .read_ready_q(rr), .region_q(reg_q), .pulse_short_q(ps), .buf_err_q(be));
   // expected region for each entry command
   function [2:0] region_of(input [7:0] c);
      case (c)
         `FPRC_CMD_SECSI: region_of = `FPRC_MODE_SECSI;
         `FPRC_CMD_CFGREG: region_of = `FPRC_MODE_CFG;
         `FPRC_CMD_LOCK: region_of = `FPRC_MODE_LOCK;
         `FPRC_CMD_ID, `FPRC_CMD_CFI: region_of = `FPRC_MODE_IDCFI;
         default: region_of = `FPRC_MODE_ARRAY;
      endcase
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks=%0d mismatches=%0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // hang guard, well above the fewer than two thousand cycles the run needs
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         complete_run;
      end
   end
   initial begin
      {reset, flash_clk, core_busy, sync_mode, core_ready, core_rdata} = {5'h10, 16'h0000};
      {err_total, num_checks, cyc} = 0;
      i = $urandom(32'hcf3c);
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge clk);
      check(rr, 1'b1);
      check(reg_q, 3'h0);
      // reset in array first, then every region entered and left
      for (i = 5; i >= 0; i = i - 1) begin
         u_host.cmd(CMDS[i*8 +: 8]);
         check(reg_q, region_of(CMDS[i*8 +: 8]));
         u_host.cmd(`FPRC_CMD_RESET);
         check(reg_q, 3'h0);
      end
      // output gate releases the bus but not the wait line
      w = wt;
      #1 u_host.out_gate_n = 1'b1;
      repeat (6) @(posedge clk);
      check(oe, 1'b0);
      check(wt, w);
      // random address and data held still, gate toggled meanwhile
      #1 u_host.bus_q = $urandom;
      core_rdata = $urandom;
      // let the moved address clear any earlier sleep before the word arrives
      repeat (4) @(posedge clk);
      #1 core_ready = 1'b1;
      @(posedge clk) #1 core_ready = 1'b0;
      repeat (12) @(posedge clk);
      #1 u_host.out_gate_n = 1'b0;
      repeat (14) @(posedge clk);
      check(sl, 1'b1);
      check(bout, core_rdata);
      check(oe, 1'b1);
      #1 sync_mode = 1'b1;
      repeat (6) @(posedge clk);
      check(sl, 1'b0);
      #1 sync_mode = 1'b0;
      // standby, a write in it ignored, busy keeps it out
      u_host.chip_sel_n = 1'b1;
      repeat (8) @(posedge clk);
      check(sb, 1'b1);
      check(oe, 1'b0);
      u_host.cmd(`FPRC_CMD_SECSI);
      check(reg_q, 3'h0);
      #1 core_busy = 1'b1;
      repeat (8) @(posedge clk);
      check(sb, 1'b0);
      #1 {core_busy, u_host.chip_sel_n} = 2'b00;
      // a short and a full reset pulse while idle, then a full one while busy
      for (i = 0; i < 3; i = i + 1) begin
         n = (i == 0) ? 10 : (i == 1) ? 130 : 630;
         u_host.cmd(`FPRC_CMD_SECSI);
         #1 core_busy = (i == 2);
         u_host.pulse(n);
         check(ps, n < ((i == 2) ? 625 : 125));
         #1 core_busy = 1'b0;
         check(reg_q, 3'h0);
         check(rr, 1'b1);
      end
      // secured-region buffer loads: a random legal count and one too long
      for (i = 0; i < 2; i = i + 1) begin
         n = (i == 0) ? ($urandom % 32) : 40;
         u_host.cmd(`FPRC_CMD_SECSI);
         u_host.cmd(`FPRC_CMD_BUFLOAD);
         u_host.cmd(n[7:0]);
         repeat (n + 1) u_host.cmd($urandom % 256);
         check(be, n > 31);
         check(reg_q, `FPRC_MODE_SECSI);
         u_host.cmd(`FPRC_CMD_RESET);
         check(reg_q, 3'h0);
      end
      complete_run;
   end
endmodule
